// [dbp_defs.svh]
/*
 * register offsets, reset values and widths of the dual byte port.
 * assumes a 16-bit register address from the cpu side and 8-bit data.
 */
`ifndef DBP_DEFS_SVH
`define DBP_DEFS_SVH

// ==========================================================
// register offsets (lower 16 bits of the address)
`define DBP_A_DIR_OFS 16'hffc1
`define DBP_A_OUT_OFS 16'hffc3
`define DBP_B_DIR_OFS 16'hffc4
`define DBP_B_OUT_OFS 16'hffc6
`define DBP_A_PUP_OFS 16'hffd8

// ==========================================================
// reset values and read answers
`define DBP_LATCH_RST 8'h00
`define DBP_DIR_RST_EXP 8'hff
`define DBP_WO_READ 8'hff
`define DBP_UNMAPPED_READ 8'h00

// ==========================================================
// widths
`define DBP_AW 16
`define DBP_DW 8

`endif

// [dbp_pin_model.sv]
/*
 * far-side pin model: resolves each pin from the port drive, an
 * external driver, the pull-up (port a only), or a toggling float otherwise.
 */
`timescale 1ns/1ps
module dbp_pin_model
	import dbp_pkg::*;
(
	input wire logic clk,
	input wire dbp_pins_s port_a_pins,
	input wire logic [7:0] port_a_pullup,
	input wire dbp_pins_s port_b_pins,
	input wire logic [7:0] ext_a,
	input wire logic [7:0] drv_a,
	input wire logic [7:0] ext_b,
	input wire logic [7:0] drv_b,
	output logic [7:0] port_a_in,
	output logic [7:0] port_b_in
);
	logic [7:0] float_r = 8'h55;
	// undriven pins change every cycle so a stale level never passes
	always_ff @(posedge clk) float_r <= ~float_r;
	// port first, then external driver, then pull-up
	assign port_a_in = (~port_a_pins.oe_n & port_a_pins.dout) | (port_a_pins.oe_n & drv_a & ext_a)
		| (port_a_pins.oe_n & ~drv_a & (port_a_pullup | float_r));
	assign port_b_in = (~port_b_pins.oe_n & port_b_pins.dout) | (port_b_pins.oe_n & drv_b & ext_b)
		| (port_b_pins.oe_n & ~drv_b & float_r);
endmodule : dbp_pin_model

// [dbp_pkg.sv]
/*
 * types shared by the dual byte port.
 * assumes dbp_defs.svh is on the include path.
 */
`include "dbp_defs.svh"

package dbp_pkg;

	// ==========================================================
	// operating mode, one-hot coded
	typedef enum logic [6:0] {
		DBP_MODE_1 = 7'h01,
		DBP_MODE_2 = 7'h02,
		DBP_MODE_3 = 7'h04,
		DBP_MODE_4 = 7'h08,
		DBP_MODE_5 = 7'h10,
		DBP_MODE_6 = 7'h20,
		DBP_MODE_7 = 7'h40
	} dbp_mode_e;

	// ==========================================================
	// register port request from the cpu
	typedef struct packed {
		logic [`DBP_AW-1:0] addr;
		logic [`DBP_DW-1:0] wdata;
		logic wr;
		logic rd;
	} dbp_req_s;

	// one byte-wide pin group: level out and active-low enable
	typedef struct packed {
		logic [`DBP_DW-1:0] dout;
		logic [`DBP_DW-1:0] oe_n;
	} dbp_pins_s;

endpackage : dbp_pkg

// [dbp_port.sv]
/*
 * dual byte port: port a (address high byte / gpio with pull-ups) and
 * port b (external data bus / gpio), with the cpu register port.
 * assumes mode pins are static straps, standby inputs come from the
 * clock/power controller on clk, and the external bus controller drives
 * the data-bus signals for port b in expanded modes.
 */
`timescale 1ns/1ps
`include "dbp_defs.svh"

module dbp_port
	import dbp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] mode_sel,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire dbp_req_s req,
	output logic [`DBP_DW-1:0] rdata,
	input wire logic [`DBP_DW-1:0] addr_hi,
	input wire logic [`DBP_DW-1:0] bus_dout,
	input wire logic bus_drive,
	output logic [`DBP_DW-1:0] bus_din,
	input wire logic [`DBP_DW-1:0] port_a_in,
	output dbp_pins_s port_a_pins,
	output logic [`DBP_DW-1:0] port_a_pullup,
	input wire logic [`DBP_DW-1:0] port_b_in,
	output dbp_pins_s port_b_pins
);

	// ==========================================================
	// helpers

	// mixes latch and pin per bit by direction
	function automatic logic [`DBP_DW-1:0] dbp_mix(input logic [`DBP_DW-1:0] dir,
		input logic [`DBP_DW-1:0] latch, input logic [`DBP_DW-1:0] pin);
		dbp_mix = (dir & latch) | (~dir & pin);
	endfunction : dbp_mix

	// ==========================================================
	// mode decode, registered once the straps settle after reset
	dbp_mode_e mode_r;
	logic expanded;
	logic rom_off;

	// mode straps are caught by a clocked process, never by the reset itself
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= DBP_MODE_7;
		end else begin
			case (mode_sel)
				7'h01: mode_r <= DBP_MODE_1;
				7'h02: mode_r <= DBP_MODE_2;
				7'h04: mode_r <= DBP_MODE_3;
				7'h08: mode_r <= DBP_MODE_4;
				7'h10: mode_r <= DBP_MODE_5;
				7'h20: mode_r <= DBP_MODE_6;
				default: mode_r <= DBP_MODE_7;
			endcase
		end
	end

	assign expanded = (mode_r != DBP_MODE_7);
	assign rom_off = (mode_r == DBP_MODE_1) || (mode_r == DBP_MODE_2) ||
		(mode_r == DBP_MODE_3) || (mode_r == DBP_MODE_4);

	// ==========================================================
	// pin synchronisers, two stages each
	logic [`DBP_DW-1:0] a_meta_r;
	logic [`DBP_DW-1:0] a_sync_r;
	logic [`DBP_DW-1:0] b_meta_r;
	logic [`DBP_DW-1:0] b_sync_r;

	// first stage is read only by the second stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_meta_r <= `DBP_LATCH_RST;
			a_sync_r <= `DBP_LATCH_RST;
			b_meta_r <= `DBP_LATCH_RST;
			b_sync_r <= `DBP_LATCH_RST;
		end else begin
			a_meta_r <= port_a_in;
			a_sync_r <= a_meta_r;
			b_meta_r <= port_b_in;
			b_sync_r <= b_meta_r;
		end
	end

	// ==========================================================
	// register decode
	logic wr_a_dir;
	logic wr_a_out;
	logic wr_a_pup;
	logic wr_b_dir;
	logic wr_b_out;

	always_comb begin
		wr_a_dir = 1'b0;
		wr_a_out = 1'b0;
		wr_a_pup = 1'b0;
		wr_b_dir = 1'b0;
		wr_b_out = 1'b0;
		if (req.wr) begin
			if (req.addr == `DBP_A_DIR_OFS) begin
				wr_a_dir = 1'b1;
			end else if (req.addr == `DBP_A_OUT_OFS) begin
				wr_a_out = 1'b1;
			end else if (req.addr == `DBP_A_PUP_OFS) begin
				wr_a_pup = 1'b1;
			end else if (req.addr == `DBP_B_DIR_OFS) begin
				wr_b_dir = 1'b1;
			end else if (req.addr == `DBP_B_OUT_OFS) begin
				wr_b_out = 1'b1;
			end
		end
	end

	// ==========================================================
	// control registers; hw standby acts as a synchronous clear
	logic [`DBP_DW-1:0] port_a_direction_r;
	logic [`DBP_DW-1:0] port_a_output_latch_r;
	logic [`DBP_DW-1:0] port_a_pullup_enable_r;
	logic [`DBP_DW-1:0] port_b_direction_r;
	logic [`DBP_DW-1:0] port_b_output_latch_r;
	logic [`DBP_DW-1:0] a_dir_eff;

	// port a direction: referenced only through a_dir_eff, for the read mux, the pull-up gating and drive
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_direction_r <= `DBP_LATCH_RST;
		end else if (hw_standby) begin
			port_a_direction_r <= `DBP_LATCH_RST;
		end else if (wr_a_dir) begin
			port_a_direction_r <= req.wdata;
		end
	end

	// modes 1-4 force every port a direction bit to output
	assign a_dir_eff = rom_off ? `DBP_DIR_RST_EXP : port_a_direction_r;

	// port a output latch, held untouched through sw standby
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_output_latch_r <= `DBP_LATCH_RST;
		end else if (hw_standby) begin
			port_a_output_latch_r <= `DBP_LATCH_RST;
		end else if (wr_a_out) begin
			port_a_output_latch_r <= req.wdata;
		end
	end

	// port a pull-up enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_pullup_enable_r <= `DBP_LATCH_RST;
		end else if (hw_standby) begin
			port_a_pullup_enable_r <= `DBP_LATCH_RST;
		end else if (wr_a_pup) begin
			port_a_pullup_enable_r <= req.wdata;
		end
	end

	// port b direction, write-only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_b_direction_r <= `DBP_LATCH_RST;
		end else if (hw_standby) begin
			port_b_direction_r <= `DBP_LATCH_RST;
		end else if (wr_b_dir) begin
			port_b_direction_r <= req.wdata;
		end
	end

	// port b output latch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_b_output_latch_r <= `DBP_LATCH_RST;
		end else if (hw_standby) begin
			port_b_output_latch_r <= `DBP_LATCH_RST;
		end else if (wr_b_out) begin
			port_b_output_latch_r <= req.wdata;
		end
	end

	// ==========================================================
	// read data, one cycle after the read strobe
	logic [`DBP_DW-1:0] rdata_nxt;

	// unmapped addresses answer zero; no wait states ever
	always_comb begin
		rdata_nxt = `DBP_UNMAPPED_READ;
		if (req.rd) begin
			if (req.addr == `DBP_A_DIR_OFS) begin
				rdata_nxt = `DBP_WO_READ;
			end else if (req.addr == `DBP_A_OUT_OFS) begin
				rdata_nxt = dbp_mix(a_dir_eff, port_a_output_latch_r, a_sync_r);
			end else if (req.addr == `DBP_A_PUP_OFS) begin
				rdata_nxt = port_a_pullup_enable_r;
			end else if (req.addr == `DBP_B_DIR_OFS) begin
				rdata_nxt = `DBP_WO_READ;
			end else if (req.addr == `DBP_B_OUT_OFS) begin
				rdata_nxt = dbp_mix(port_b_direction_r, port_b_output_latch_r, b_sync_r);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= `DBP_UNMAPPED_READ;
		end else begin
			rdata <= rdata_nxt;
		end
	end

	// ==========================================================
	// port a drive: address byte in expanded modes, latch in mode 7
	logic [`DBP_DW-1:0] a_dout_nxt;
	logic [`DBP_DW-1:0] a_pup_nxt;

	assign a_dout_nxt = expanded ? addr_hi : port_a_output_latch_r;

	// pull-ups only on inputs and never in modes 1-4; hw standby forces off
	assign a_pup_nxt = (rom_off || hw_standby) ? `DBP_LATCH_RST :
		(port_a_pullup_enable_r & ~a_dir_eff);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_pins.dout <= `DBP_LATCH_RST;
			port_a_pins.oe_n <= `DBP_DIR_RST_EXP;
			port_a_pullup <= `DBP_LATCH_RST;
		end else begin
			port_a_pins.dout <= a_dout_nxt;
			port_a_pins.oe_n <= hw_standby ? `DBP_DIR_RST_EXP : ~a_dir_eff;
			port_a_pullup <= a_pup_nxt;
		end
	end

	// ==========================================================
	// port b drive: external data bus in modes 1-6, gpio in mode 7
	// sw standby leaves latch and direction alone, so outputs keep driving
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_b_pins.dout <= `DBP_LATCH_RST;
			port_b_pins.oe_n <= `DBP_DIR_RST_EXP;
			bus_din <= `DBP_LATCH_RST;
		end else begin
			bus_din <= b_sync_r;
			if (hw_standby) begin
				port_b_pins.dout <= `DBP_LATCH_RST;
				port_b_pins.oe_n <= `DBP_DIR_RST_EXP;
			end else if (expanded) begin
				port_b_pins.dout <= bus_dout;
				port_b_pins.oe_n <= {`DBP_DW{~bus_drive}};
			end else begin
				port_b_pins.dout <= port_b_output_latch_r;
				port_b_pins.oe_n <= ~port_b_direction_r;
			end
		end
	end

endmodule : dbp_port

// [dbp_port_assertions.sv]
/*
 * checker for the dual byte port pin and read-back timing.
 * assumes clean one-hot mode straps and binding onto dbp_port.
 */
`timescale 1ns/1ps
`include "dbp_defs.svh"
module dbp_port_assertions
	import dbp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] mode_sel,
	input wire logic hw_standby,
	input wire dbp_req_s req,
	input wire logic [7:0] rdata,
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] bus_dout,
	input wire logic bus_drive,
	input wire dbp_pins_s port_a_pins,
	input wire logic [7:0] port_a_pullup,
	input wire dbp_pins_s port_b_pins
);
	// ==========================================================
	// one domain; mode is registered, pins one edge later
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_bus; (|mode_sel[5:0]) [*2]; endsequence
	sequence s_rom_off; (|mode_sel[3:0]) [*2]; endsequence
	a_rd_idle: assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not idle");
	a_dir_reads_ones: assert property (req.rd && (req.addr == `DBP_B_DIR_OFS || req.addr == `DBP_A_DIR_OFS)
		|=> rdata == 8'hff) else $error("direction read not all ones");
	a_pup_exp_off: assert property (s_rom_off ##1 (|mode_sel[3:0]) |-> port_a_pullup == 8'h00)
		else $error("pull-up on in modes 1-4");
	a_pup_hw_off: assert property (hw_standby |-> ##2 port_a_pullup == 8'h00)
		else $error("pull-up on after hw standby");
	a_pup_on_input: assert property ((port_a_pullup & ~port_a_pins.oe_n) == 8'h00)
		else $error("pull-up on a driven pin");
	a_b_data_bus: assert property (s_bus |=> port_b_pins.dout == $past(bus_dout)
		&& port_b_pins.oe_n == {8{!$past(bus_drive)}}) else $error("port b not data bus");
	a_a_addr_out: assert property (s_rom_off |=> port_a_pins.oe_n == 8'h00
		&& port_a_pins.dout == $past(addr_hi)) else $error("port a not address out");
	a_b_write_lands: assert property (req.wr && req.addr == `DBP_B_OUT_OFS && mode_sel == 7'h40 && !hw_standby
		|=> ##1 port_b_pins.dout == $past(req.wdata, 2)) else $error("port b write lost");
endmodule : dbp_port_assertions

// [tb_top.sv]
/*
 * testbench for dbp_port with the pin model on the far side.
 * assumes a 100 MHz clock and mode 7 straps out of reset.
 */
`timescale 1ns/1ps
`include "dbp_defs.svh"
module tb_top
	import dbp_pkg::*;
;
	logic clk, arst_n, hw_standby, sw_standby, bus_drive;
	logic [6:0] mode_sel;
	dbp_req_s req;
	dbp_pins_s port_a_pins, port_b_pins;
	logic [7:0] rdata, addr_hi, bus_dout, bus_din, port_a_in, port_a_pullup, port_b_in;
	logic [7:0] ext_a, drv_a, ext_b, drv_b;
	int num_errors = 0;
	int checked = 0;
	dbp_port dbp_port_i (.clk, .arst_n, .mode_sel, .hw_standby, .sw_standby, .req, .rdata, .addr_hi,
		.bus_dout, .bus_drive, .bus_din, .port_a_in, .port_a_pins, .port_a_pullup, .port_b_in, .port_b_pins);
	dbp_pin_model dbp_pin_model_i (.clk, .port_a_pins, .port_a_pullup, .port_b_pins, .ext_a, .drv_a,
		.ext_b, .drv_b, .port_a_in, .port_b_in);
	// ==========================================================
	// helpers
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		req.wr <= 1'h0;
	endtask : wr
	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		req.rd <= 1'h0;
		#1 chk("rdata", rdata, e);
	endtask : rd
	task automatic complete_run();
		if (num_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	// ==========================================================
	// scenarios
	task automatic t_reset_map(); // reset values and write-only reads
		rd(`DBP_B_DIR_OFS, 8'hff);
		rd(`DBP_A_PUP_OFS, 8'h00);
		rd(16'hff00, 8'h00);
		wr(`DBP_B_DIR_OFS, 8'hff);
		rd(`DBP_B_OUT_OFS, 8'h00);
		wr(`DBP_A_DIR_OFS, 8'hff);
		rd(`DBP_A_OUT_OFS, 8'h00);
	endtask : t_reset_map
	task automatic t_gpio(); // mixed directions, pin levels and pull-ups
		wr(`DBP_B_DIR_OFS, 8'h0f);
		wr(`DBP_B_OUT_OFS, 8'ha5);
		wr(`DBP_A_DIR_OFS, 8'hf0);
		wr(`DBP_A_OUT_OFS, 8'h96);
		wr(`DBP_A_PUP_OFS, 8'hff);
		ext_b <= 8'h3c;
		drv_a <= 8'h00;
		step(4);
		chk("b_oe_n", port_b_pins.oe_n, 8'hf0);
		chk("a_pullup", port_a_pullup, 8'h0f);
		rd(`DBP_B_OUT_OFS, 8'h35);
		rd(`DBP_A_OUT_OFS, 8'h9f);
	endtask : t_gpio
	task automatic t_standby(); // soft standby holds, hard standby clears
		@(posedge clk);
		sw_standby <= 1'h1;
		step(4);
		chk("b_dout", port_b_pins.dout, 8'ha5);
		chk("a_pullup", port_a_pullup, 8'h0f);
		@(posedge clk);
		sw_standby <= 1'h0;
		rd(`DBP_A_PUP_OFS, 8'hff);
		rd(`DBP_A_OUT_OFS, 8'h9f);
		@(posedge clk);
		hw_standby <= 1'h1;
		@(posedge clk);
		hw_standby <= 1'h0;
		step(2);
		chk("a_pullup", port_a_pullup, 8'h00);
		chk("b_oe_n", port_b_pins.oe_n, 8'hff);
		rd(`DBP_A_PUP_OFS, 8'h00);
		wr(`DBP_B_DIR_OFS, 8'hff);
		rd(`DBP_B_OUT_OFS, 8'h00);
	endtask : t_standby
	task automatic t_expanded(); // modes 1 to 6 hand pins to the bus
		wr(`DBP_A_PUP_OFS, 8'hff);
		wr(`DBP_A_DIR_OFS, 8'h00);
		bus_dout <= 8'hc3;
		bus_drive <= 1'h1;
		for (int m = 0; m < 6; m++) begin
			@(posedge clk);
			mode_sel <= 7'h01 << m;
			addr_hi <= 8'h10 + 8'(m);
			step(6);
			chk("b_dout", port_b_pins.dout, 8'hc3);
			chk("bus_din", bus_din, 8'hc3);
			chk("a_pullup", port_a_pullup, (m < 4) ? 8'h00 : 8'hff);
			chk("a_oe_n", port_a_pins.oe_n, (m < 4) ? 8'h00 : 8'hff);
			chk("a_dout", port_a_pins.dout, 8'h10 + 8'(m));
		end
		@(posedge clk);
		bus_drive <= 1'h0;
		step(3);
		chk("b_oe_n", port_b_pins.oe_n, 8'hff);
		mode_sel <= 7'h40;
	endtask : t_expanded
	// ==========================================================
	// clock, reset and sequence
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		arst_n = 1'h0;
		mode_sel = 7'h40;
		hw_standby = 1'h0;
		sw_standby = 1'h0;
		req = '0;
		addr_hi = 8'h00;
		bus_dout = 8'h00;
		bus_drive = 1'h0;
		ext_a = 8'h00;
		drv_a = 8'hff;
		ext_b = 8'h00;
		drv_b = 8'hff;
		repeat (2) @(posedge clk);
		arst_n <= 1'h1;
		t_reset_map();
		t_gpio();
		t_standby();
		t_expanded();
		complete_run();
	end
endmodule : tb_top
bind dbp_port dbp_port_assertions dbp_port_assertions_i (.clk, .arst_n, .mode_sel, .hw_standby, .req,
	.rdata, .addr_hi, .bus_dout, .bus_drive, .port_a_pins, .port_a_pullup, .port_b_pins);
